// file: rtl/analog_limit_monitor.sv
// Analog limit monitor: consolidation, limits, mute, bypass and error handling
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module analog_limit_monitor
    import alm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Sensor values and diagnostics
    input wire logic signed [31:0] ain1_i,
    input wire logic signed [31:0] ain2_i,
    input wire logic short_i,
    input wire logic open_i,
    input wire logic warn_i,
    input wire logic run_i,
    // Control pins
    input wire logic mute_i,
    input wire logic bypass_i,
    input wire logic err_reset_i,
    // Outputs
    output logic [3:0] release_o,
    output logic cond_o,
    output logic mute_act_o,
    output logic byp_act_o,
    output logic reset_req_o,
    output logic error_o,
    output logic warning_o
);
    logic [31:0] ctrl;
    logic [15:0] mute_lim;
    logic [15:0] byp_lim;
    logic [31:0] tol_abs;
    logic [15:0] tol_rel;
    logic [15:0] tol_time;
    logic signed [31:0] lim_on [4];
    logic signed [31:0] lim_off [4];

    logic [31:0] tick_cnt;
    logic tick;
    logic [2:0] mute_sync;
    logic [2:0] byp_sync;
    logic [2:0] rst_sync;
    logic mute_prev;
    logic byp_prev;
    logic rst_prev;
    logic mute_rise;
    logic byp_rise;
    logic rst_fall;

    gate_state_t mute_st;
    gate_state_t byp_st;
    logic [31:0] mute_cnt;
    logic [31:0] byp_cnt;
    logic [3:0] held;

    logic signed [31:0] cons;
    logic [32:0] delta;
    logic [31:0] cons_mag;
    logic [31:0] tol_rel_val;
    logic [32:0] tol_eff;
    logic exceed;
    logic [15:0] tol_cnt;
    logic tol_err;
    logic run_prev;
    logic start_win;
    logic [15:0] start_cnt;

    logic rst_armed;
    logic [31:0] hi_cnt;
    logic [31:0] deb_min;
    logic reset_ok;
    logic cause;
    logic err_lat;

    logic [3:0] lim_en;
    logic [3:0] cmp;
    logic [3:0] next_release;

    // Configuration views
    logic reset_man;
    logic tlim_en;
    logic [2:0] cons_sel;
    logic [2:0] tol_type;
    logic [3:0] mute_resp;
    logic [3:0] byp_resp;

    assign reset_man = ctrl[CTRL_RST_MAN];
    assign tlim_en = ctrl[CTRL_TLIM_EN];
    assign cons_sel = ctrl[CTRL_CONS_LSB +: 3];
    assign tol_type = ctrl[CTRL_TOL_LSB +: 3];
    assign mute_resp = ctrl[CTRL_MRESP_LSB +: 4];
    assign byp_resp = ctrl[CTRL_BRESP_LSB +: 4];

    // Register writes
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= CTRL_RESET;
            mute_lim <= MUTE_LIM_RESET;
            byp_lim <= BYP_LIM_RESET;
            tol_abs <= 32'h0000_0000;
            tol_rel <= 16'h0000;
            tol_time <= 16'h0000;
            for (int i = 0; i < 4; i++)
            begin
                lim_on[i] <= 32'sh0000_0000;
                lim_off[i] <= 32'sh0000_0000;
            end
        end
        else if (wr_i)
        begin
            unique case (addr_i)
                OFS_CTRL: ctrl <= wdata_i;
                OFS_MUTE_LIM: mute_lim <= wdata_i[15:0];
                OFS_BYP_LIM: byp_lim <= wdata_i[15:0];
                OFS_TOL_ABS: tol_abs <= wdata_i;
                OFS_TOL_REL: tol_rel <= wdata_i[15:0];
                OFS_TOL_TIME: tol_time <= wdata_i[15:0];
                default:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (addr_i == OFS_LIM_BASE + 8'(8 * i))
                            lim_on[i] <= wdata_i;
                        if (addr_i == OFS_LIM_BASE + 8'(8 * i + 4))
                            lim_off[i] <= wdata_i;
                    end
                end
            endcase
        end
    end

    // Register reads, data valid only in the cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !rd_i)
            rdata_o <= 32'h0000_0000;
        else
        begin
            rdata_o <= 32'h0000_0000;
            unique case (addr_i)
                OFS_CTRL: rdata_o <= ctrl;
                OFS_MUTE_LIM: rdata_o <= {16'h0000, mute_lim};
                OFS_BYP_LIM: rdata_o <= {16'h0000, byp_lim};
                OFS_TOL_ABS: rdata_o <= tol_abs;
                OFS_TOL_REL: rdata_o <= {16'h0000, tol_rel};
                OFS_TOL_TIME: rdata_o <= {16'h0000, tol_time};
                OFS_STATUS: rdata_o <= {16'h0000, err_lat, start_win, warning_o,
                    error_o, reset_req_o, byp_act_o, mute_act_o, cond_o,
                    cmp, release_o};
                OFS_CONS: rdata_o <= cons;
                default:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (addr_i == OFS_LIM_BASE + 8'(8 * i))
                            rdata_o <= lim_on[i];
                        if (addr_i == OFS_LIM_BASE + 8'(8 * i + 4))
                            rdata_o <= lim_off[i];
                    end
                end
            endcase
        end
    end

    // Millisecond timebase
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || tick)
            tick_cnt <= 32'h0000_0000;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // Pin synchronisers and edge detection
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mute_sync <= 3'h7;
            byp_sync <= 3'h7;
            rst_sync <= 3'h7;
        end
        else
        begin
            mute_sync <= {mute_sync[1:0], mute_i};
            byp_sync <= {byp_sync[1:0], bypass_i};
            rst_sync <= {rst_sync[1:0], err_reset_i};
        end
    end
    assign mute_prev = mute_sync[2];
    assign byp_prev = byp_sync[2];
    assign rst_prev = rst_sync[2];
    assign mute_rise = mute_sync[1] && !mute_prev;
    assign byp_rise = byp_sync[1] && !byp_prev;
    assign rst_fall = !rst_sync[1] && rst_prev;

    // Muting
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mute_st <= GATE_IDLE;
            mute_cnt <= 32'h0000_0000;
            held <= 4'h0;
        end
        else
        begin
            unique case (mute_st)
                GATE_IDLE:
                begin
                    if (mute_rise && ctrl[CTRL_MUTE_EN])
                    begin
                        mute_st <= GATE_ON;
                        mute_cnt <= 32'h0000_0000;
                        held <= release_o & mute_resp & lim_en;
                    end
                end
                GATE_ON:
                begin
                    if (!mute_sync[1] || (tlim_en && mute_cnt >= mute_lim * MS_PER_S))
                    begin
                        mute_st <= GATE_IDLE;
                        held <= 4'h0;
                    end
                    else if (tick)
                        mute_cnt <= mute_cnt + 32'h0000_0001;
                end
                default:
                    mute_st <= GATE_IDLE;
            endcase
        end
    end

    // Bypass
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            byp_st <= GATE_IDLE;
            byp_cnt <= 32'h0000_0000;
        end
        else
        begin
            unique case (byp_st)
                GATE_IDLE:
                begin
                    if (byp_rise && ctrl[CTRL_BYP_EN])
                    begin
                        byp_st <= GATE_ON;
                        byp_cnt <= 32'h0000_0000;
                    end
                end
                GATE_ON:
                begin
                    if (!byp_sync[1] || (tlim_en && byp_cnt >= byp_lim * MS_PER_MIN))
                        byp_st <= GATE_IDLE;
                    else if (tick)
                        byp_cnt <= byp_cnt + 32'h0000_0001;
                end
                default:
                    byp_st <= GATE_IDLE;
            endcase
        end
    end

    // Consolidation and channel deviation
    always_comb
    begin
        logic [32:0] sum;
        logic [32:0] diff;
        logic [47:0] prod;
        sum = {ain1_i[31], ain1_i} + {ain2_i[31], ain2_i};
        diff = {ain1_i[31], ain1_i} - {ain2_i[31], ain2_i};
        prod = 48'h0000_0000_0000;
        cons = ain1_i;
        if (ctrl[CTRL_DUAL])
        begin
            unique case (cons_sel)
                CONS_CH2: cons = ain2_i;
                CONS_MAX: cons = (ain1_i >= ain2_i) ? ain1_i : ain2_i;
                CONS_MIN: cons = (ain1_i <= ain2_i) ? ain1_i : ain2_i;
                CONS_AVG: cons = sum[32:1];
                default: cons = ain1_i;
            endcase
        end
        delta = diff[32] ? (33'h0 - diff) : diff;
        cons_mag = cons[31] ? (32'h0 - cons) : cons;
        prod = {16'h0000, cons_mag} * {32'h0000_0000, tol_rel};
        tol_rel_val = 32'(prod / PCT_DIV);
        unique case (tol_type)
            TOL_ABS: tol_eff = {1'b0, tol_abs};
            TOL_REL: tol_eff = {1'b0, tol_rel_val};
            TOL_OR: tol_eff = {1'b0, (tol_abs < tol_rel_val) ? tol_abs : tol_rel_val};
            TOL_AND: tol_eff = {1'b0, (tol_abs > tol_rel_val) ? tol_abs : tol_rel_val};
            default: tol_eff = {1'b0, tol_abs};
        endcase
        exceed = ctrl[CTRL_DUAL] && (tol_type < TOL_NONE) && (delta > tol_eff);
    end

    // Tolerance time
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !exceed)
            tol_cnt <= 16'h0000;
        else if (tick && tol_cnt < tol_time)
            tol_cnt <= tol_cnt + 16'h0001;
    end
    assign tol_err = exceed && (tol_cnt >= tol_time);

    // Start-up window after STOP to START
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            run_prev <= 1'b0;
            start_win <= 1'b0;
            start_cnt <= 16'h0000;
        end
        else
        begin
            run_prev <= run_i;
            if (run_i && !run_prev && tol_time != 16'h0000 && ctrl[CTRL_DUAL])
            begin
                start_win <= 1'b1;
                start_cnt <= 16'h0000;
            end
            else if (start_win && (start_cnt >= tol_time || !run_i))
                start_win <= 1'b0;
            else if (start_win && tick)
                start_cnt <= start_cnt + 16'h0001;
        end
    end

    // Error reset pulse qualification
    always_comb
    begin
        unique case (ctrl[CTRL_DEB_LSB +: 2])
            2'h0: deb_min = DEB_MS_1;
            2'h2: deb_min = DEB_MS_350;
            default: deb_min = DEB_MS_100;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rst_armed <= 1'b0;
            hi_cnt <= 32'h0000_0000;
            reset_ok <= 1'b0;
        end
        else
        begin
            reset_ok <= rst_fall && rst_armed && hi_cnt >= deb_min
                && hi_cnt <= PULSE_MAX_MS;
            if (!rst_sync[1])
            begin
                rst_armed <= 1'b1;
                hi_cnt <= 32'h0000_0000;
            end
            else if (tick && hi_cnt <= PULSE_MAX_MS)
                hi_cnt <= hi_cnt + 32'h0000_0001;
        end
    end

    // Error state
    assign cause = short_i || open_i || (warn_i && ctrl[CTRL_WARN_ACT]) || tol_err;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            err_lat <= 1'b0;
        else if (cause)
            err_lat <= 1'b1;
        else if (!reset_man || reset_ok)
            err_lat <= 1'b0;
    end

    // Limit comparators
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_lim
            assign lim_en[g] = (2'(g) <= ctrl[CTRL_NLIM_LSB +: 2]);
            lim_hyst u_hyst (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .value_i(cons),
                .on_thr_i(lim_on[g]),
                .off_thr_i(lim_off[g]),
                .below_i(ctrl[CTRL_BELOW_LSB + g]),
                .enable_i(lim_en[g]),
                .active_o(cmp[g])
            );
        end
    endgenerate

    // Release combination
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            next_release[i] = (byp_st == GATE_ON && byp_resp[i] && lim_en[i])
                || (!err_lat && !cause
                && (cmp[i] || held[i] || (start_win && lim_en[i])));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            release_o <= 4'h0;
            cond_o <= 1'b0;
            mute_act_o <= 1'b0;
            byp_act_o <= 1'b0;
            reset_req_o <= 1'b0;
            error_o <= 1'b0;
            warning_o <= 1'b0;
        end
        else
        begin
            release_o <= next_release;
            cond_o <= |cmp;
            mute_act_o <= (mute_st == GATE_ON);
            byp_act_o <= (byp_st == GATE_ON);
            reset_req_o <= err_lat && !cause && reset_man;
            error_o <= short_i || open_i || tol_err;
            warning_o <= warn_i;
        end
    end
endmodule : analog_limit_monitor

// file: rtl/alm_pkg.sv
// Constants, register map and types for the analog limit monitor
package alm_pkg;
    // Timebase
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam logic [31:0] MS_PER_S = 32'h0000_03e8;
    localparam logic [31:0] MS_PER_MIN = 32'h0000_ea60;
    localparam logic [31:0] PULSE_MAX_MS = 32'h0000_7530;
    localparam logic [31:0] DEB_MS_1 = 32'h0000_0001;
    localparam logic [31:0] DEB_MS_100 = 32'h0000_0064;
    localparam logic [31:0] DEB_MS_350 = 32'h0000_015e;
    localparam logic [47:0] PCT_DIV = 48'h0000_0000_0064;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MUTE_LIM = 8'h04;
    localparam logic [7:0] OFS_BYP_LIM = 8'h08;
    localparam logic [7:0] OFS_TOL_ABS = 8'h0c;
    localparam logic [7:0] OFS_TOL_REL = 8'h10;
    localparam logic [7:0] OFS_TOL_TIME = 8'h14;
    localparam logic [7:0] OFS_LIM_BASE = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_CONS = 8'h44;

    // Control register fields
    localparam int CTRL_RST_MAN = 1;
    localparam int CTRL_MUTE_EN = 2;
    localparam int CTRL_BYP_EN = 3;
    localparam int CTRL_TLIM_EN = 4;
    localparam int CTRL_WARN_ACT = 5;
    localparam int CTRL_NLIM_LSB = 6;
    localparam int CTRL_DUAL = 8;
    localparam int CTRL_CONS_LSB = 9;
    localparam int CTRL_TOL_LSB = 12;
    localparam int CTRL_DEB_LSB = 16;
    localparam int CTRL_MRESP_LSB = 20;
    localparam int CTRL_BRESP_LSB = 24;
    localparam int CTRL_BELOW_LSB = 28;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0ff1_4030;
    localparam logic [15:0] MUTE_LIM_RESET = 16'h1c20;
    localparam logic [15:0] BYP_LIM_RESET = 16'h0258;

    // Consolidation choices
    localparam logic [2:0] CONS_CH1 = 3'h0;
    localparam logic [2:0] CONS_CH2 = 3'h1;
    localparam logic [2:0] CONS_MAX = 3'h2;
    localparam logic [2:0] CONS_MIN = 3'h3;
    localparam logic [2:0] CONS_AVG = 3'h4;

    // Tolerance types
    localparam logic [2:0] TOL_ABS = 3'h0;
    localparam logic [2:0] TOL_REL = 3'h1;
    localparam logic [2:0] TOL_OR = 3'h2;
    localparam logic [2:0] TOL_AND = 3'h3;
    localparam logic [2:0] TOL_NONE = 3'h4;

    typedef enum logic [1:0] {
        GATE_IDLE = 2'b01,
        GATE_ON = 2'b10
    } gate_state_t;
endpackage : alm_pkg

// file: rtl/lim_hyst.sv
// One limit value comparator with switch-on and switch-off thresholds
`timescale 1ns/1ps
module lim_hyst
    import alm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Comparison
    input wire logic signed [31:0] value_i,
    input wire logic signed [31:0] on_thr_i,
    input wire logic signed [31:0] off_thr_i,
    input wire logic below_i,
    input wire logic enable_i,
    output logic active_o
);
    logic hit_on;
    logic hit_off;

    always_comb
    begin
        hit_on = below_i ? (value_i <= on_thr_i) : (value_i >= on_thr_i);
        hit_off = below_i ? (value_i >= off_thr_i) : (value_i <= off_thr_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !enable_i)
            active_o <= 1'b0;
        else if (!active_o && hit_on)
            active_o <= 1'b1;
        else if (active_o && hit_off)
            active_o <= 1'b0;
    end
endmodule : lim_hyst

// file: verification/analog_limit_monitor_properties.sv
// Port assertions for the analog limit monitor
`timescale 1ns/1ps
module analog_limit_monitor_properties
    import alm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // Clock, reset and register port
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Pins and outputs
    input wire logic short_i,
    input wire logic open_i,
    input wire logic warn_i,
    input wire logic mute_i,
    input wire logic bypass_i,
    input wire logic [3:0] release_o,
    input wire logic mute_act_o,
    input wire logic byp_act_o,
    input wire logic error_o
);
    localparam logic [31:0] RW_MASK = 32'hfff3_7ffe;
    logic [31:0] ctrl;
    logic [3:0] lim_en;
    logic [3:0] byp_set;

    // Software view of the control register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ctrl <= CTRL_RESET;
        else if (wr_i && addr_i == OFS_CTRL)
            ctrl <= wdata_i & RW_MASK;
    end
    assign lim_en = 4'hf >> (2'h3 - ctrl[7:6]);
    assign byp_set = lim_en & ctrl[27:24];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    mute_latency_a: assert property ($rose(mute_act_o) |-> $past(mute_i, 4))
        else $error("mute active without a mute edge");
    mute_enable_a: assert property (mute_act_o |-> ctrl[CTRL_MUTE_EN])
        else $error("mute active while disabled");
    bypass_latency_a: assert property ($rose(byp_act_o) |-> $past(bypass_i, 4))
        else $error("bypass active without a bypass edge");
    bypass_forces_a: assert property (byp_act_o |-> (release_o & byp_set) == byp_set)
        else $error("bypass did not force releases");
    fault_drop_a: assert property ((short_i || open_i) |=>
        error_o && (release_o == 4'h0 || byp_act_o))
        else $error("sensor fault did not drop releases");
    warn_drop_a: assert property (warn_i && ctrl[CTRL_WARN_ACT] |=>
        release_o == 4'h0 || byp_act_o)
        else $error("acting warning did not drop releases");
    ctrl_readback_a: assert property (rd_i && addr_i == OFS_CTRL |=>
        (rdata_o & RW_MASK) == ctrl)
        else $error("control readback wrong");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (rd_i && addr_i == 8'hfc |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : analog_limit_monitor_properties

bind analog_limit_monitor analog_limit_monitor_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .short_i, .open_i,
    .warn_i, .mute_i, .bypass_i, .release_o, .mute_act_o, .byp_act_o, .error_o
);

// file: verification/sensor_model.sv
// Sensor pair and reset-pulse source seen by the monitor
`timescale 1ns/1ps
module sensor_model
(
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic signed [31:0] val_i,
    input wire logic signed [31:0] dev_i,
    input wire logic pulse_i,
    // Sensor side
    output logic signed [31:0] ain1_o,
    output logic signed [31:0] ain2_o,
    output logic err_reset_o
);
    int hold;
    initial
    begin
        hold = 0;
        ain1_o = 32'h0;
        ain2_o = 32'h0;
        err_reset_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        ain1_o <= val_i;
        ain2_o <= val_i + dev_i;
        // Low-high-low, 40 cycles high
        if (pulse_i)
            hold <= 40;
        else if (hold > 0)
            hold <= hold - 1;
        err_reset_o <= (hold > 0);
    end
endmodule : sensor_model

// file: verification/analog_limit_monitor_test.sv
// Self-checking bench for the analog limit monitor
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
$display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module analog_limit_monitor_test;
    import alm_pkg::*;
    int n_checks = 0;
    int miscompares = 0;
    int k;
    logic clk_i = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic signed [31:0] val = 32'h0;
    logic signed [31:0] dev = 32'h0;
    logic signed [31:0] ain1;
    logic signed [31:0] ain2;
    logic pulse = 1'b0;
    logic ers;
    logic shrt = 1'b0;
    logic opn = 1'b0;
    logic warn = 1'b0;
    logic run = 1'b1;
    logic mute = 1'b1;
    logic byp = 1'b1;
    logic [3:0] rel;
    logic cond;
    logic mact;
    logic bact;
    logic rreq;
    logic err;
    logic wrn;
    logic [31:0] lim_v [4] = '{32'h6a4, 32'h9c4, 32'h6a4, 32'h190};
    logic [3:0] lim_e [4] = '{4'h1, 4'h3, 4'h3, 4'h0};
    logic [31:0] cons_v [5] = '{32'h3e8, 32'hbb8, 32'hbb8, 32'h3e8, 32'h7d0};
    logic [4:0] tol_e [5] = '{5'h0f, 5'h10, 5'h10, 5'h0f, 5'h0f};

    always #5 clk_i = ~clk_i;

    analog_limit_monitor #(.TICK_CYCLES(10)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .ain1_i(ain1), .ain2_i(ain2), .short_i(shrt), .open_i(opn),
        .warn_i(warn), .run_i(run), .mute_i(mute), .bypass_i(byp), .err_reset_i(ers),
        .release_o(rel), .cond_o(cond), .mute_act_o(mact), .byp_act_o(bact),
        .reset_req_o(rreq), .error_o(err), .warning_o(wrn)
    );
    sensor_model pm (.clk_i(clk_i), .val_i(val), .dev_i(dev), .pulse_i(pulse),
        .ain1_o(ain1), .ain2_o(ain2), .err_reset_o(ers));

    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        v = rdata;
    endtask : rd_reg
    task give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task t_regs;
        rd_reg(OFS_CTRL, d);
        `CHK(d[7:0], 8'h30)
        rd_reg(OFS_MUTE_LIM, d);
        `CHK(d[15:0], 16'h1c20)
        rd_reg(OFS_BYP_LIM, d);
        `CHK(d[15:0], 16'h0258)
        rd_reg(8'hfc, d);
        `CHK(d, 32'h0)
        $display("registers done");
    endtask : t_regs
    task t_start;
        wr_reg(OFS_CTRL, 32'h0ff1_403c);
        wt(20);
        `CHK({mact, bact}, 2'b00)
        mute <= 1'b0;
        byp <= 1'b0;
        $display("start done");
    endtask : t_start
    task t_limits;
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFS_LIM_BASE + 8'(8 * i), 32'(i + 1) * 32'h3e8);
            wr_reg(OFS_LIM_BASE + 8'(8 * i + 4), 32'(i + 1) * 32'h3e8 - 32'h1f4);
        end
        wr_reg(OFS_CTRL, 32'h0ff1_40f0);
        for (int i = 0; i < 4; i++)
        begin
            val <= lim_v[i];
            wt(5);
            `CHK(rel, lim_e[i])
            `CHK(cond, |lim_e[i])
        end
        wr_reg(OFS_CTRL, 32'h1ff1_40f0);
        wt(5);
        `CHK(rel, 4'h1)
        $display("limits done");
    endtask : t_limits
    task t_mute;
        wr_reg(OFS_MUTE_LIM, 32'h1);
        wr_reg(OFS_CTRL, 32'h0ff1_40f4);
        val <= 32'h6a4;
        wt(5);
        mute <= 1'b1;
        wt(7);
        `CHK(mact, 1'b1)
        val <= 32'h9c4;
        wt(5);
        `CHK(rel, 4'h3)
        val <= 32'h0;
        wt(5);
        `CHK(rel, 4'h1)
        for (k = 0; k < 12000 && mact; k++)
            @(posedge clk_i);
        `CHK(k > 9900 && k < 10100, 1'b1)
        if (k == 12000)
            give_verdict;
        wt(3);
        `CHK(rel, 4'h0)
        mute <= 1'b0;
        wr_reg(OFS_CTRL, 32'h0ff1_40e4);
        val <= 32'h6a4;
        wt(5);
        mute <= 1'b1;
        wt(7);
        val <= 32'h0;
        wt(40);
        `CHK(rel, 4'h1)
        mute <= 1'b0;
        wt(7);
        `CHK({mact, rel}, 5'h00)
        $display("mute done");
    endtask : t_mute
    task t_bypass;
        wr_reg(OFS_CTRL, 32'h0ff1_40e8);
        byp <= 1'b1;
        wt(7);
        `CHK({bact, rel}, 5'h1f)
        byp <= 1'b0;
        wt(7);
        `CHK({bact, rel}, 5'h00)
        wr_reg(OFS_BYP_LIM, 32'h0);
        wr_reg(OFS_CTRL, 32'h0ff1_40f8);
        byp <= 1'b1;
        wt(8);
        `CHK({bact, rel}, 5'h00)
        byp <= 1'b0;
        $display("bypass done");
    endtask : t_bypass
    task t_fault;
        wr_reg(OFS_CTRL, 32'h0ff1_40f0);
        val <= 32'h6a4;
        wt(5);
        shrt <= 1'b1;
        wt(3);
        `CHK({err, rel}, 5'h10)
        shrt <= 1'b0;
        wt(6);
        `CHK({err, rel}, 5'h01)
        warn <= 1'b1;
        wt(3);
        `CHK(rel, 4'h0)
        `CHK(wrn, 1'b1)
        warn <= 1'b0;
        wr_reg(OFS_CTRL, 32'h0ff1_40f2);
        opn <= 1'b1;
        wt(3);
        opn <= 1'b0;
        wt(6);
        `CHK({rreq, rel}, 5'h10)
        pulse <= 1'b1;
        wt(1);
        pulse <= 1'b0;
        wt(55);
        `CHK({rreq, rel}, 5'h10)
        wr_reg(OFS_CTRL, 32'h0ff0_40f2);
        pulse <= 1'b1;
        wt(1);
        pulse <= 1'b0;
        wt(55);
        `CHK({rreq, rel}, 5'h01)
        $display("fault done");
    endtask : t_fault
    task t_dual;
        wr_reg(OFS_TOL_TIME, 32'h0);
        wr_reg(OFS_TOL_ABS, 32'h3e8);
        wr_reg(OFS_TOL_REL, 32'h5);
        val <= 32'h3e8;
        dev <= 32'h7d0;
        for (int c = 0; c < 5; c++)
        begin
            wr_reg(OFS_CTRL, 32'h0ff1_41f0 | (32'(c) << 9));
            wt(5);
            rd_reg(OFS_CONS, d);
            `CHK(d, cons_v[c])
        end
        val <= 32'h2710;
        for (int t = 0; t < 5; t++)
        begin
            dev <= 32'h0;
            wr_reg(OFS_CTRL, 32'h0ff1_01f0 | (32'(t) << 12));
            wt(8);
            dev <= 32'h320;
            wt(8);
            `CHK({err, rel}, tol_e[t])
        end
        dev <= 32'h0;
        wr_reg(OFS_TOL_TIME, 32'h5);
        wr_reg(OFS_CTRL, 32'h0ff1_11f0);
        wt(8);
        dev <= 32'h320;
        wt(25);
        `CHK({err, rel}, 5'h0f)
        wt(45);
        `CHK(err, 1'b1)
        dev <= 32'h0;
        val <= 32'h0;
        run <= 1'b0;
        wt(8);
        `CHK(rel, 4'h0)
        run <= 1'b1;
        wt(5);
        `CHK(rel, 4'hf)
        wt(60);
        `CHK(rel, 4'h0)
        $display("dual done");
    endtask : t_dual

    initial
    begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        give_verdict;
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_n <= 1'b1;
        t_regs;
        t_start;
        t_limits;
        t_mute;
        t_bypass;
        t_fault;
        t_dual;
        give_verdict;
    end
endmodule : analog_limit_monitor_test
